// ==== design/sfr_pkg.sv ====
package sfr_pkg;
    localparam logic [7:0]  OP_READ     = 8'h03;
    localparam logic [7:0]  OP_FAST     = 8'h0B;
    localparam logic [7:0]  OP_DOUT     = 8'h3B;
    localparam logic [7:0]  OP_DIO      = 8'hBB;
    localparam logic [7:0]  OP_QOUT     = 8'h6B;
    localparam logic [7:0]  OP_QIO      = 8'hEB;
    localparam logic [7:0]  OP_QIO_S    = 8'hE7;
    localparam int          ADDR_W      = 24;
    localparam logic [23:0] ADDR_TOP    = 24'hFFFFFF;
    localparam logic [23:0] ADDR_ZERO   = 24'h000000;
    localparam logic [4:0]  CNT_ZERO    = 5'h00;
    localparam logic [4:0]  CNT_ONE     = 5'h01;
    localparam logic [4:0]  OP_CLKS     = 5'h08;
    localparam logic [4:0]  ADDR_CLKS_1 = 5'h18;
    localparam logic [4:0]  ADDR_CLKS_2 = 5'h0C;
    localparam logic [4:0]  ADDR_CLKS_4 = 5'h06;
    localparam logic [4:0]  IND_CLKS    = 5'h02;
    localparam logic [4:0]  DUMMY_8     = 5'h08;
    localparam logic [4:0]  DUMMY_4     = 5'h04;
    localparam logic [4:0]  DUMMY_2     = 5'h02;
    localparam logic [3:0]  IND_TOGGLE  = 4'hF;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [3:0]  MASK_1      = 4'h2;
    localparam logic [3:0]  MASK_2      = 4'h3;
    localparam logic [3:0]  MASK_4      = 4'hF;
    localparam logic [2:0]  SYNC_LO     = 3'h0;
    localparam logic [2:0]  SYNC_HI     = 3'h7;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000, ST_ADDR  = 3'b001, ST_IND = 3'b010,
        ST_DUMMY  = 3'b011, ST_DATA  = 3'b100, ST_IGNORE = 3'b101
    } sfr_state_t;

    typedef enum logic [2:0] {
        CMD_READ = 3'b000, CMD_FAST = 3'b001, CMD_DOUT  = 3'b010,
        CMD_DIO  = 3'b011, CMD_QOUT = 3'b100, CMD_QIO   = 3'b101,
        CMD_QIO_S = 3'b110
    } sfr_cmd_t;

    typedef enum logic [1:0] {
        LANE_1 = 2'b00, LANE_2 = 2'b01, LANE_4 = 2'b10
    } sfr_lane_t;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } sfr_pin_in_t;

    typedef struct packed {
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } sfr_pin_out_t;
endpackage : sfr_pkg

// ==== design/sfr_read_front.sv ====
`timescale 1ns/1ps
// What this block does
// R1: address sampled on rise, data on fall
// R2: 03 then address, data without dummy
// R3: address increments per byte, wraps to zero
// R4: select high ends read anytime
// R5: 0B adds one dummy byte
// R6: busy rejects fast, dual, quad-out reads
// R7: 3B: eight dummies, two-line data out
// R8: BB: two-line address, four dummies
// R9: host keeps first two dual dummies steady
// R10: 6B: eight dummies, four-line data out
// R11: quad I/O read needs quad enable
// R12: EB: four-line address, 2+4 dummies
// R13: E7 like EB with four dummies; the code gives E7 two dummy clocks after the two indicator clocks
// R14: toggling indicator keeps continuous mode
// R15: steady indicator drops continuous mode
// R16: host drives lines during indicator clocks
// R17: quad enable turns pins into data
// R18: FF on one line ends continuous mode
// R19: most significant bit first, top line
// R20: select high: hi-z, decoder reset
module sfr_read_front (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire sfr_pkg::sfr_pin_in_t pins_in,
    input  wire logic                 quad_enable_bit,
    input  wire logic                 write_busy,
    input  wire logic [7:0]           mem_rdata,
    output sfr_pkg::sfr_pin_out_t     pins_out,
    output logic [23:0]               mem_addr,
    output logic                      cont_mode
);
    import sfr_pkg::*;

    logic [2:0] sck_s_q;
    logic [2:0] cs_s_q;
    logic [3:0] io_s0_q;
    logic [3:0] io_s1_q;
    logic [3:0] io_s2_q;
    logic       sck_lvl_q;
    logic       cs_lvl_q;
    logic       sck_rise;
    logic       sck_fall;
    sfr_state_t state_q;
    sfr_cmd_t   cmd_q;
    logic [4:0] cnt_q;
    logic [7:0] sh_q;
    logic [23:0] addr_q;
    logic       cont_q;
    logic [7:0] dsh_q;
    logic [3:0] left_q;
    logic [3:0] io_out_q;
    logic [3:0] io_oe_q;
    logic [7:0] op_next;
    logic       byte_load;
    logic       ind_tog;

    ////////////////////////////////////////////////////////////////////
    function automatic logic op_ok(logic [7:0] op, logic busy,
                                   logic qe);
        case (op)
            OP_READ:                  op_ok = 1'b1;
            OP_FAST, OP_DOUT, OP_DIO: op_ok = !busy;
            OP_QOUT, OP_QIO, OP_QIO_S: op_ok = !busy && qe;
            default:                  op_ok = 1'b0;
        endcase
    endfunction : op_ok
    function automatic sfr_cmd_t op_cmd(logic [7:0] op);
        case (op)
            OP_FAST:  op_cmd = CMD_FAST;
            OP_DOUT:  op_cmd = CMD_DOUT;
            OP_DIO:   op_cmd = CMD_DIO;
            OP_QOUT:  op_cmd = CMD_QOUT;
            OP_QIO:   op_cmd = CMD_QIO;
            OP_QIO_S: op_cmd = CMD_QIO_S;
            default:  op_cmd = CMD_READ;
        endcase
    endfunction : op_cmd
    function automatic sfr_lane_t addr_lanes(sfr_cmd_t c);
        case (c)
            CMD_DIO:            addr_lanes = LANE_2;
            CMD_QIO, CMD_QIO_S: addr_lanes = LANE_4;
            default:            addr_lanes = LANE_1;
        endcase
    endfunction : addr_lanes
    function automatic sfr_lane_t data_lanes(sfr_cmd_t c);
        case (c)
            CMD_DOUT, CMD_DIO:            data_lanes = LANE_2;
            CMD_QOUT, CMD_QIO, CMD_QIO_S: data_lanes = LANE_4;
            default:                      data_lanes = LANE_1;
        endcase
    endfunction : data_lanes

    function automatic logic [4:0] addr_clks(sfr_lane_t l);
        case (l)
            LANE_2:  addr_clks = ADDR_CLKS_2;
            LANE_4:  addr_clks = ADDR_CLKS_4;
            default: addr_clks = ADDR_CLKS_1;
        endcase
    endfunction : addr_clks

    function automatic logic [4:0] dummy_clks(sfr_cmd_t c);
        case (c)
            CMD_FAST, CMD_DOUT, CMD_QOUT: dummy_clks = DUMMY_8;
            CMD_DIO, CMD_QIO:             dummy_clks = DUMMY_4;
            CMD_QIO_S:                    dummy_clks = DUMMY_2;
            default:                      dummy_clks = CNT_ZERO;
        endcase
    endfunction : dummy_clks

    function automatic logic [3:0] lane_n(sfr_lane_t l);
        case (l)
            LANE_2:  lane_n = 4'h2;
            LANE_4:  lane_n = 4'h4;
            default: lane_n = 4'h1;
        endcase
    endfunction : lane_n

    function automatic logic [3:0] lane_mask(sfr_lane_t l, logic qe);
        case (l)
            LANE_2:  lane_mask = MASK_2;
            LANE_4:  lane_mask = qe ? MASK_4 : MASK_2;
            default: lane_mask = MASK_1;
        endcase
    endfunction : lane_mask

    // top bits of the byte onto the lines, high line first
    function automatic logic [3:0] out_group(logic [7:0] b,
                                             sfr_lane_t l);
        case (l)
            LANE_2:  out_group = {2'b00, b[7:6]};
            LANE_4:  out_group = b[7:4];
            default: out_group = {2'b00, b[7], 1'b0};
        endcase
    endfunction : out_group

    function automatic logic [23:0] shift_in(logic [23:0] a,
                                             sfr_lane_t l,
                                             logic [3:0] io);
        case (l)
            LANE_2:  shift_in = {a[21:0], io[1:0]};
            LANE_4:  shift_in = {a[19:0], io};
            default: shift_in = {a[22:0], io[0]};
        endcase
    endfunction : shift_in

    function automatic sfr_state_t after_ind(sfr_cmd_t c);
        after_ind = (dummy_clks(c) == CNT_ZERO) ? ST_DATA : ST_DUMMY;
    endfunction : after_ind

    ////////////////////////////////////////////////////////////////////
    // three-stage sync; a level counts once stages two and three agree
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_s_q <= SYNC_LO;
            cs_s_q  <= SYNC_HI;
            io_s0_q <= 4'h0;
            io_s1_q <= 4'h0;
            io_s2_q <= 4'h0;
        end else begin
            sck_s_q <= {sck_s_q[1:0], pins_in.sck};
            cs_s_q  <= {cs_s_q[1:0], pins_in.cs_n};
            io_s0_q <= pins_in.io;
            io_s1_q <= io_s0_q;
            io_s2_q <= io_s1_q;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_lvl_q <= 1'b0;
            cs_lvl_q  <= 1'b1;
        end else begin
            if (sck_s_q[1] == sck_s_q[2]) sck_lvl_q <= sck_s_q[2];
            if (cs_s_q[1] == cs_s_q[2]) cs_lvl_q <= cs_s_q[2];
        end
    end

    assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2]
                      && !sck_lvl_q && !cs_lvl_q;
    assign sck_fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2]
                      && sck_lvl_q && !cs_lvl_q;
    assign op_next   = {sh_q[6:0], io_s2_q[0]};
    assign byte_load = sck_fall && state_q == ST_DATA
                       && left_q == 4'h0;
    assign ind_tog   = (sh_q[3:0] ^ io_s2_q) == IND_TOGGLE;

    ////////////////////////////////////////////////////////////////////
    // command sequencer, on serial clock rising edges
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_OPCODE;
            cmd_q   <= CMD_READ;
            cnt_q   <= CNT_ZERO;
            sh_q    <= 8'h00;
        end else if (cs_lvl_q) begin
            state_q <= cont_q ? ST_ADDR : ST_OPCODE; // R20 R4 R14
            cnt_q   <= CNT_ZERO;
        end else if (sck_rise) begin // R1
            cnt_q <= cnt_q + CNT_ONE;
            case (state_q)
                ST_OPCODE: begin
                    sh_q <= op_next; // R19
                    if (cnt_q == OP_CLKS - CNT_ONE) begin
                        cnt_q <= CNT_ZERO;
                        if (op_ok(op_next, write_busy,
                                  quad_enable_bit)) begin // R6 R11
                            cmd_q   <= op_cmd(op_next);
                            state_q <= ST_ADDR; // R2 R5 R7 R10
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (cnt_q == addr_clks(addr_lanes(cmd_q))
                                 - CNT_ONE) begin // R8 R12
                        cnt_q <= CNT_ZERO;
                        if (cmd_q == CMD_QIO || cmd_q == CMD_QIO_S)
                            state_q <= ST_IND;
                        else
                            state_q <= after_ind(cmd_q); // R2
                    end
                end
                ST_IND: begin
                    sh_q <= {sh_q[3:0], io_s2_q};
                    if (cnt_q == IND_CLKS - CNT_ONE) begin
                        cnt_q   <= CNT_ZERO;
                        state_q <= after_ind(cmd_q); // R12 R13
                    end
                end
                ST_DUMMY: begin
                    if (cnt_q == dummy_clks(cmd_q) - CNT_ONE) begin
                        cnt_q   <= CNT_ZERO;
                        state_q <= ST_DATA; // R5 R7 R8 R10
                    end
                end
                ST_DATA, ST_IGNORE: cnt_q <= CNT_ZERO;
                default: state_q <= ST_IGNORE;
            endcase
        end
    end

    // address: shifted in on rises, advanced once per output byte
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q <= ADDR_ZERO;
        end else if (sck_rise && state_q == ST_ADDR) begin
            addr_q <= shift_in(addr_q, addr_lanes(cmd_q), io_s2_q);
        end else if (byte_load) begin
            addr_q <= addr_q + 24'h000001; // R3
        end
    end

    // continuous mode follows the indicator nibbles
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cont_q <= 1'b0;
        end else if (sck_rise && state_q == ST_IND
                     && cnt_q == IND_CLKS - CNT_ONE) begin
            cont_q <= ind_tog; // R14 R15 R18
        end
    end

    // data out on falling edges, lines released with select high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            io_out_q <= 4'h0;
            io_oe_q  <= 4'h0;
            dsh_q    <= 8'h00;
            left_q   <= 4'h0;
        end else if (cs_lvl_q) begin
            io_oe_q <= 4'h0; // R20 R4
            left_q  <= 4'h0;
        end else if (sck_fall && state_q == ST_DATA) begin // R1
            io_oe_q <= lane_mask(data_lanes(cmd_q),
                                 quad_enable_bit); // R17
            if (left_q == 4'h0) begin
                io_out_q <= out_group(mem_rdata, data_lanes(cmd_q));
                dsh_q    <= mem_rdata << lane_n(data_lanes(cmd_q));
                left_q   <= BYTE_BITS - lane_n(data_lanes(cmd_q));
            end else begin
                io_out_q <= out_group(dsh_q, data_lanes(cmd_q)); // R19
                dsh_q    <= dsh_q << lane_n(data_lanes(cmd_q));
                left_q   <= left_q - lane_n(data_lanes(cmd_q));
            end
        end
    end

    assign pins_out.io_out = io_out_q;
    assign pins_out.io_oe  = io_oe_q;
    assign mem_addr        = addr_q;
    assign cont_mode       = cont_q;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    sequence s_op_end;
        sck_rise && state_q == ST_OPCODE && cnt_q == OP_CLKS - CNT_ONE;
    endsequence
    sequence s_ind_end;
        sck_rise && state_q == ST_IND && cnt_q == IND_CLKS - CNT_ONE;
    endsequence
    select_hiz_a: assert property (cs_lvl_q && !cont_q |=> // R20
        state_q == ST_OPCODE && io_oe_q == 4'h0 && cnt_q == CNT_ZERO)
        else $error("select high did not reset the decoder");
    drive_fall_a: assert property ($changed(io_out_q) |-> // R1
        $past(sck_fall))
        else $error("data changed off a falling edge");
    addr_cause_a: assert property ($changed(addr_q) |-> // R1
        $past(sck_rise) || $past(byte_load))
        else $error("address changed without a cause");
    addr_wrap_a: assert property (byte_load && addr_q == ADDR_TOP // R3
        |=> addr_q == ADDR_ZERO)
        else $error("address did not wrap to zero");
    read_direct_a: assert property (sck_rise && state_q == ST_ADDR // R2
        && cmd_q == CMD_READ && cnt_q == ADDR_CLKS_1 - CNT_ONE
        |=> state_q == ST_DATA)
        else $error("plain read did not go straight to data");
    busy_reject_a: assert property (s_op_end ##0 write_busy // R6
        && op_next == OP_FAST |=> state_q == ST_IGNORE)
        else $error("busy did not reject the command");
    quad_gate_a: assert property (|io_oe_q[3:2] |-> // R17
        quad_enable_bit)
        else $error("quad lines driven without quad enable");
    qio_gate_a: assert property (s_op_end ##0 !quad_enable_bit // R11
        && op_next == OP_QIO |=> state_q == ST_IGNORE)
        else $error("quad read taken without quad enable");
    cont_keep_a: assert property (s_ind_end ##0 ind_tog |=> // R14
        cont_q ##1 (!cs_lvl_q || state_q != ST_OPCODE))
        else $error("toggling indicator did not hold mode");
    cont_skip_a: assert property (cs_lvl_q && cont_q |=> // R14 R20
        state_q == ST_ADDR && io_oe_q == 4'h0)
        else $error("continuous mode did not skip the opcode");
    cont_drop_a: assert property (s_ind_end ##0 !ind_tog |=> // R15
        !cont_q)
        else $error("steady indicator kept continuous mode");
endmodule : sfr_read_front

// ==== bench/sfr_host_model.sv ====
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic                  clock,
    input  wire sfr_pkg::sfr_pin_out_t pins_out,
    output sfr_pkg::sfr_pin_in_t       pins_in
);
    import sfr_pkg::*;
    logic       cs_n;
    logic       sck;
    logic       drv;
    logic [3:0] hio;
    logic [3:0] junk;

    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        drv  = 1'b0;
        hio  = 4'hF;
        junk = 4'h6;
    end

    // undriven lines show a changing pattern, never a stale value
    always_ff @(posedge clock) begin
        junk <= junk + 4'h5;
    end

    assign pins_in.cs_n = cs_n;
    assign pins_in.sck  = sck;
    assign pins_in.io   = (pins_out.io_oe & pins_out.io_out)
                        | (~pins_out.io_oe & (drv ? hio : junk));

    ////////////////////////////////////////////////////////////////////////
    task automatic begin_frame();
        @(posedge clock);
        cs_n <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : begin_frame

    task automatic end_frame();
        @(posedge clock);
        cs_n <= 1'b1;
        drv  <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : end_frame

    // one serial clock: line set while low, sampled late in high phase
    task automatic cyc(input logic d, input logic [3:0] v,
                       output logic [3:0] seen);
        @(posedge clock);
        hio <= v;
        drv <= d;
        repeat (3) @(posedge clock);
        sck <= 1'b1;
        repeat (4) @(posedge clock);
        seen = pins_in.io;
        sck <= 1'b0;
    endtask : cyc

    // msb first, top line carries the top bit of each group
    task automatic send(input logic [31:0] val, input int nbits,
                        input int lanes);
        logic [31:0] s;
        logic [3:0]  v;
        logic [3:0]  seen;
        s = val << (32 - nbits);
        for (int i = 0; i < nbits; i += lanes) begin
            if (lanes == 4) v = s[31:28];
            else if (lanes == 2) v = {2'b11, s[31:30]};
            else v = {3'b111, s[31]};
            cyc(1'b1, v, seen);
            s = s << lanes;
        end
    endtask : send

    task automatic read_byte(input int lanes, output logic [7:0] b,
                             output logic [3:0] oe);
        logic [3:0] seen;
        b = 8'h00;
        for (int i = 0; i < 8 / lanes; i++) begin
            cyc(1'b0, 4'h0, seen);
            if (lanes == 4) b = {b[3:0], seen};
            else if (lanes == 2) b = {b[5:0], seen[1:0]};
            else b = {b[6:0], seen[1]};
            oe = pins_out.io_oe;
        end
    endtask : read_byte
endmodule : sfr_host_model

// ==== bench/sfr_read_front_tb_top.sv ====
`timescale 1ns/1ps
module sfr_read_front_tb_top;
    import sfr_pkg::*;
    logic                  clock;
    logic                  sys_rst;
    logic                  quad_enable_bit;
    logic                  write_busy;
    logic [7:0]            mem_rdata;
    sfr_pin_in_t           pins_in;
    sfr_pin_out_t          pins_out;
    logic [23:0]           mem_addr;
    logic                  cont_mode;
    int                    err_count;
    int                    samples_checked;
    int                    cycle_count;
    logic [31:0]           seed;
    logic [7:0]            ops [7];
    logic [7:0]            cut_b;
    logic [3:0]            cut_oe;

    sfr_read_front dut (
        .clock           (clock),
        .sys_rst         (sys_rst),
        .pins_in         (pins_in),
        .quad_enable_bit (quad_enable_bit),
        .write_busy      (write_busy),
        .mem_rdata       (mem_rdata),
        .pins_out        (pins_out),
        .mem_addr        (mem_addr),
        .cont_mode       (cont_mode)
    );

    sfr_host_model host (
        .clock    (clock),
        .pins_out (pins_out),
        .pins_in  (pins_in)
    );

    function automatic logic [7:0] mem_fn(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
    endfunction : mem_fn

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    assign mem_rdata = mem_fn(mem_addr);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_mask(input string n, input logic [3:0] e,
                            input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_mask

    task automatic chk_flag(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask : chk_flag

    task automatic chk_addr(input string n, input logic [23:0] e,
                            input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_addr

    // c indexes ops; ok says whether the device should answer
    task automatic frame(input int c, input logic [23:0] a, input int n,
                         input logic [7:0] ind, input bit cont,
                         input bit ok);
        int         al;
        int         dl;
        logic [7:0] b;
        logic [3:0] oe;
        al = (c == 3) ? 2 : (c >= 5) ? 4 : 1;
        dl = (c <= 1) ? 1 : (c <= 3) ? 2 : 4;
        host.begin_frame();
        if (!cont) host.send({24'h0, ops[c]}, 8, 1);
        host.send({8'h0, a}, 24, al);
        if (c == 1 || c == 2 || c == 4) host.send(32'h0, 8, 1);
        if (c == 3) host.send(32'h0, 8, 2);
        if (c >= 5) host.send({24'h0, ind}, 8, 4);
        if (c == 5) host.send(32'h0, 16, 4);
        if (c == 6) host.send(32'h0, 8, 4);
        for (int k = 0; k < n; k++) begin
            host.read_byte(dl, b, oe);
            if (ok) chk_byte("data", mem_fn(a + 24'(k)), b);
            if (ok) chk_addr("addr", a + 24'(k + 1), mem_addr);
            if (!ok) chk_mask("oe", 4'h0, oe);
            else if (dl == 1) chk_mask("oe", MASK_1, oe);
            else if (dl == 2) chk_mask("oe", MASK_2, oe);
            else chk_mask("oe", MASK_4, oe);
        end
        host.end_frame();
        chk_mask("oe_idle", 4'h0, pins_out.io_oe);
    endtask : frame

    always @(posedge clock) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        ops = '{OP_READ, OP_FAST, OP_DOUT, OP_DIO, OP_QOUT, OP_QIO,
                OP_QIO_S};
        err_count = 0;
        samples_checked = 0;
        cycle_count = 0;
        seed = 32'h8C147A8A;
        sys_rst = 1'b1;
        quad_enable_bit = 1'b1;
        write_busy = 1'b0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk_mask("rst_oe", 4'h0, pins_out.io_oe);
        chk_flag("rst_cont", 1'b0, cont_mode);
        repeat (6) @(posedge clock);
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 7; c++) begin
                frame(c, (r == 0) ? 24'hFFFFFE : 24'(rnd()),
                      3, 8'hFF, 1'b0, 1'b1);
                chk_flag("cont", 1'b0, cont_mode);
            end
        end
        write_busy <= 1'b1;
        for (int c = 1; c < 7; c++) begin
            frame(c, 24'(rnd()), 1, 8'hFF, 1'b0, 1'b0);
        end
        frame(0, 24'(rnd()), 2, 8'hFF, 1'b0, 1'b1);
        write_busy <= 1'b0;
        quad_enable_bit <= 1'b0;
        frame(5, 24'(rnd()), 1, 8'hA5, 1'b0, 1'b0);
        frame(4, 24'(rnd()), 1, 8'hFF, 1'b0, 1'b0);
        chk_flag("cont", 1'b0, cont_mode);
        quad_enable_bit <= 1'b1;
        frame(5, 24'(rnd()), 2, 8'hA5, 1'b0, 1'b1);
        chk_flag("cont", 1'b1, cont_mode);
        frame(5, 24'(rnd()), 2, 8'h00, 1'b1, 1'b1);
        chk_flag("cont", 1'b0, cont_mode);
        frame(0, 24'(rnd()), 1, 8'hFF, 1'b0, 1'b1);
        frame(6, 24'(rnd()), 1, 8'h5A, 1'b0, 1'b1);
        chk_flag("cont", 1'b1, cont_mode);
        host.begin_frame();
        host.send(32'hFF, 8, 1);
        host.end_frame();
        chk_flag("cont", 1'b0, cont_mode);
        host.begin_frame();
        host.send(32'hFF, 8, 1);
        host.read_byte(1, cut_b, cut_oe);
        host.end_frame();
        chk_mask("oe_ff", 4'h0, cut_oe);
        frame(0, 24'(rnd()), 2, 8'hFF, 1'b0, 1'b1);
        host.begin_frame();
        host.send({24'h0, OP_READ}, 8, 1);
        host.send({8'h0, 24'(rnd())}, 24, 1);
        host.read_byte(2, cut_b, cut_oe);
        host.end_frame();
        chk_mask("oe_cut", MASK_1, cut_oe);
        chk_mask("oe_end", 4'h0, pins_out.io_oe);
        frame(1, 24'(rnd()), 2, 8'hFF, 1'b0, 1'b1);
        wrap_up();
    end
endmodule : sfr_read_front_tb_top
